// ---- verilog/ssra_consts.vh ----
// Constants for the serial slave register access port.
`ifndef SSRA_CONSTS_VH
`define SSRA_CONSTS_VH
`define SSRA_CTL_ADDR_WR 8'h40
`define SSRA_CTL_DATA_WR 8'h00
`define SSRA_CTL_DATA_RD 8'h80
`define SSRA_CTL_ADDR_RD 8'hC0
`define SSRA_BYTE_BITS 4'h8
`define SSRA_ADDR_RESET 8'h00
`endif

// ---- verilog/ssra_slave.v ----
// Serial slave port giving an external master access to the internal register space.
// Contract
// - Slave only; never drives the clock.
// - First serial clock rise enters serial mode.
// - Sixteen bits: control byte then data MSB-first.
// - Writes keep serial output high impedance.
// - Reads drive the requested byte out.
// - Select high between bytes pauses transaction.
// - Stopped clock keeps state unchanged.
// - Split control byte discarded; expect control.
// - Split write data byte discarded; expect data.
// - Split read byte aborts output; expect data.
// - Invalid control byte ignored; expect control.
// - Control 40h latches register address.
// - Control 00h writes data to selected register.
// - Only last address write selects target.
// - Control 80h reads selected register.
// - Control C0h returns selected address.
// - Gaps any length; back-to-back under select.
`timescale 1ns/10ps
`include "ssra_consts.vh"
module ssra_slave
(
   input wire clk,
   input wire rst_n,
   input wire serial_clock,
   input wire slave_select_n,
   input wire serial_in,
   output reg serial_out,
   output reg serial_out_oe_n,
   output reg serial_mode,
   output reg [7:0] reg_addr,
   output reg reg_wr,
   output reg [7:0] reg_wr_data,
   output reg reg_rd,
   input wire [7:0] reg_rd_data
);

   reg [1:0] sclk_sync_ff;
   reg [1:0] sel_sync_ff;
   reg [1:0] sin_sync_ff;
   reg sclk_prev_ff;
   reg sel_prev_ff;
   reg data_phase_ff;
   reg read_ff;
   reg addr_rd_ff;
   reg addr_ctl_ff;
   reg [3:0] bit_cnt_ff;
   reg [7:0] shift_ff;
   reg [7:0] tx_ff;
   reg tx_armed_ff;
   reg rd_pending_ff;

   wire sclk_s = sclk_sync_ff[1];
   wire sel_n_s = sel_sync_ff[1];
   wire sin_s = sin_sync_ff[1];
   wire sclk_rise = sclk_s & ~sclk_prev_ff;
   wire sclk_fall = ~sclk_s & sclk_prev_ff;
   wire sel_rise = sel_n_s & ~sel_prev_ff;
   wire [7:0] rx_byte = {shift_ff[6:0], sin_s};
   wire byte_done = sclk_rise & ~sel_n_s & (bit_cnt_ff == `SSRA_BYTE_BITS - 4'h1);

   function ctl_valid;
      input [7:0] c;
      begin
         ctl_valid = (c[5:0] == 6'h00);
      end
   endfunction

   // All pins are asynchronous to clk, so each passes two flip-flops.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_sync_ff <= 2'h0;
         sel_sync_ff <= 2'h3;
         sin_sync_ff <= 2'h0;
         sclk_prev_ff <= 1'h0;
         sel_prev_ff <= 1'h1;
      end
      else
      begin
         sclk_sync_ff <= {sclk_sync_ff[0], serial_clock};
         sel_sync_ff <= {sel_sync_ff[0], slave_select_n};
         sin_sync_ff <= {sin_sync_ff[0], serial_in};
         sclk_prev_ff <= sclk_s;
         sel_prev_ff <= sel_n_s;
      end
   end

   // Shared decodes of the receive and transmit events.
   wire rx_edge = sclk_rise & ~sel_n_s;
   wire rd_ctl = rx_byte[7] & ~rx_byte[6];
   wire ctl_done = byte_done & ~data_phase_ff & ctl_valid(rx_byte);
   wire data_done = byte_done & data_phase_ff;
   wire wr_done = data_done & ~read_ff;
   wire tx_off = sel_n_s | ~data_phase_ff | ~read_ff;
   wire [7:0] tx_src = addr_rd_ff ? reg_addr : reg_rd_data;
   wire tx_load = ~tx_off & ~tx_armed_ff & ~rd_pending_ff & ~reg_rd;
   wire tx_shift = ~tx_off & tx_armed_ff & sclk_fall & (bit_cnt_ff != 4'h0);

   // Serial mode is entered once and kept until reset.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_mode <= 1'h0;
      end
      else if (sclk_rise)
      begin
         serial_mode <= 1'h1;
      end
   end

   // Bit position inside the current byte.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_cnt_ff <= 4'h0;
      end
      else if (sel_rise)
      begin
         // A partly received byte is dropped; the phase stays as it was.
         bit_cnt_ff <= 4'h0;
      end
      else if (byte_done)
      begin
         bit_cnt_ff <= 4'h0;
      end
      else if (rx_edge)
      begin
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
   end

   // Bits are taken on the rising edge only; a halted clock freezes everything.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_ff <= 8'h00;
      end
      else if (rx_edge)
      begin
         shift_ff <= rx_byte;
      end
   end

   // Phase flag: low while a control byte is expected.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_phase_ff <= 1'h0;
      end
      else if (ctl_done)
      begin
         data_phase_ff <= 1'h1;
      end
      else if (data_done)
      begin
         data_phase_ff <= 1'h0;
      end
   end

   // Decoded control fields, kept for the whole data byte.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         read_ff <= 1'h0;
         addr_ctl_ff <= 1'h0;
         addr_rd_ff <= 1'h0;
      end
      else if (ctl_done)
      begin
         read_ff <= rx_byte[7];
         addr_ctl_ff <= rx_byte[6];
         addr_rd_ff <= rx_byte[7] & rx_byte[6];
      end
   end

   // Fetch register data early so it is ready before the first data bit.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_pending_ff <= 1'h0;
      end
      else if (reg_rd)
      begin
         rd_pending_ff <= 1'h0;
      end
      else if (ctl_done)
      begin
         rd_pending_ff <= rd_ctl;
      end
   end

   // One read strobe per data-read control byte.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rd <= 1'h0;
      end
      else
      begin
         reg_rd <= ctl_done & rd_ctl;
      end
   end

   // Only a completed address write moves the selected register.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_addr <= `SSRA_ADDR_RESET;
      end
      else if (wr_done & addr_ctl_ff)
      begin
         reg_addr <= rx_byte;
      end
   end

   // Write data is held until the next completed data write.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_wr_data <= 8'h00;
      end
      else if (wr_done & ~addr_ctl_ff)
      begin
         reg_wr_data <= rx_byte;
      end
   end

   // One write strobe per completed data write.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_wr <= 1'h0;
      end
      else
      begin
         reg_wr <= wr_done & ~addr_ctl_ff;
      end
   end

   // Restart of a split read sends the whole byte again from its MSB.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_armed_ff <= 1'h0;
      end
      else if (tx_off)
      begin
         tx_armed_ff <= 1'h0;
      end
      else if (tx_load)
      begin
         tx_armed_ff <= 1'h1;
      end
   end

   // Output shifter: loaded when the data phase of a read begins, advanced on falling edges.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_ff <= 8'h00;
      end
      else if (tx_load)
      begin
         tx_ff <= {tx_src[6:0], 1'h0};
      end
      else if (tx_shift)
      begin
         tx_ff <= {tx_ff[6:0], 1'h0};
      end
   end

   // The MSB is driven before the first data rise; later bits follow each falling edge.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_out <= 1'h0;
      end
      else if (tx_load)
      begin
         serial_out <= tx_src[7];
      end
      else if (tx_shift)
      begin
         serial_out <= tx_ff[7];
      end
   end

   // The output is released as soon as select goes high or the read ends.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_out_oe_n <= 1'h1;
      end
      else if (tx_off)
      begin
         serial_out_oe_n <= 1'h1;
      end
      else if (tx_load)
      begin
         serial_out_oe_n <= 1'h0;
      end
   end

endmodule // ssra_slave

// ---- dv/ssra_slave_sva.sv ----
// Assertions watching the serial slave port.
`timescale 1ns/10ps
module ssra_chk
(
   input wire clk,
   input wire rst_n,
   input wire serial_clock,
   input wire slave_select_n,
   input wire serial_out_oe_n,
   input wire serial_mode,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sel_hiz_a: assert property (slave_select_n [*5] |-> serial_out_oe_n) else $error("oe on");
   wr_hiz_a: assert property (reg_wr |-> serial_out_oe_n) else $error("oe in wr");
   wr_pulse_a: assert property (reg_wr |=> !reg_wr) else $error("wr long");
   rd_pulse_a: assert property (reg_rd |=> !reg_rd) else $error("rd long");
   one_op_a: assert property (!(reg_wr && reg_rd)) else $error("wr rd");
   mode_set_a: assert property (reg_wr |-> serial_mode) else $error("mode");
   addr_only_a: assert property ($changed(reg_addr) |-> !reg_wr && !reg_rd) else $error("addr");
   clk_stop_a: assert property ($stable(serial_clock) [*8] |-> $stable(reg_addr)) else $error("moved");
   cover property (reg_wr);
   cover property (reg_rd);
   cover property ($fell(serial_out_oe_n));
endmodule // ssra_chk
bind ssra_slave ssra_chk ssra_chk_inst (.clk(clk), .rst_n(rst_n), .serial_clock(serial_clock),
   .slave_select_n(slave_select_n), .serial_out_oe_n(serial_out_oe_n), .serial_mode(serial_mode),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd));

// ---- dv/ssra_mst.sv ----
// Serial master model for the slave port.
`timescale 1ns/10ps
module ssra_mst
(
   input wire clk,
   output logic serial_clock = 1'b0,
   output logic slave_select_n = 1'b1,
   output logic serial_in = 1'b0,
   input wire serial_out
);
   // Sends n bits of w MSB first; the clock stands low outside frames.
   // Callers send control and data without any foreign access in between.
   task automatic xfer(input int n, input logic [15:0] w, output logic [7:0] r);
      for (int i = 15; i > 15 - n; i--)
      begin
         slave_select_n <= 1'b0;
         serial_in <= w[i];
         repeat (4) @(posedge clk);
         r = {r[6:0], serial_out};
         serial_clock <= 1'b1;
         repeat (4) @(posedge clk);
         serial_clock <= 1'b0;
      end
      serial_in <= ~serial_in;
   endtask
   task automatic idle();
      slave_select_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
endmodule // ssra_mst

// ---- dv/ssra_slave_tb.sv ----
// Self-checking bench for the serial slave port.
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; $display("BAD %0t %h %h", $time, a, e); end end
module ssra_slave_tb;
   logic clk = 0, rst_n = 0, sck, sel_n, sdi, sdo, oe_n, mode, wr, rd;
   logic [7:0] addr, wdat, rdat = 8'h00, r, wd;
   int bad_count = 0, cmp_count = 0, wn = 0;
   always #25 clk = ~clk;
   always @(posedge clk) rdat <= addr ^ 8'h5A;
   always @(posedge clk) wn <= wn + wr;
   always @(posedge clk) if (wr) wd <= wdat;
   ssra_slave ssra_slave_inst (.clk(clk), .rst_n(rst_n), .serial_clock(sck), .slave_select_n(sel_n),
      .serial_in(sdi), .serial_out(sdo), .serial_out_oe_n(oe_n), .serial_mode(mode), .reg_addr(addr),
      .reg_wr(wr), .reg_wr_data(wdat), .reg_rd(rd), .reg_rd_data(rdat));
   ssra_mst ssra_mst_inst (.clk(clk), .serial_clock(sck), .slave_select_n(sel_n), .serial_in(sdi),
      .serial_out(oe_n ? clk : sdo));
   task s(int n, logic [15:0] w);
      ssra_mst_inst.xfer(n, w, r);
   endtask
   task d();
      ssra_mst_inst.idle();
   endtask
   task t_addr();
      s(16, 16'h40A5);
      s(16, 16'h4033);
      d();
      `CHK(addr, 8'h33)
      `CHK(wn, 0)
      `CHK(mode, 1'b1)
   endtask
   task t_wr();
      s(16, 16'h005A);
      s(16, 16'h00C3);
      d();
      `CHK(wn, 2)
      `CHK(wd, 8'hC3)
   endtask
   task t_rd();
      s(16, 16'h8000);
      `CHK(r, 8'h69)
      s(16, 16'hC000);
      `CHK(r, 8'h33)
      s(8, 16'h8000);
      d();
      s(8, 16'h0000);
      `CHK(r, 8'h69)
   endtask
   task t_split();
      s(4, 16'h4000);
      d();
      s(16, 16'h40E1);
      s(12, 16'h00F0);
      d();
      s(8, 16'h9600);
      d();
      `CHK(addr, 8'hE1)
      `CHK(wd, 8'h96)
      s(12, 16'h8000);
      d();
      s(8, 16'h0000);
      `CHK(r, 8'hBB)
   endtask
   task t_bad();
      s(8, 16'h4100);
      s(16, 16'h4077);
      d();
      `CHK(addr, 8'h77)
   endtask
   task tally_and_finish();
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #500000;
      bad_count++;
      tally_and_finish();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(mode, 1'b0)
      t_addr();
      t_wr();
      t_rd();
      t_split();
      t_bad();
      tally_and_finish();
   end
endmodule // ssra_slave_tb
